/* File: verilog/sdm_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SDM_MAP_SVH
`define SDM_MAP_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SDM_CLK_NS 4
`define SDM_CYCLE_US 250
`define SDM_CYCLE_CLKS (`SDM_CYCLE_US * 1000 / `SDM_CLK_NS)
`define SDM_CYC_PER_MS (1000 / `SDM_CYCLE_US)
`define SDM_TP_NS 500
`define SDM_TP_CLKS ((`SDM_TP_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)
`define SDM_TP_REP_CYC 8
`define SDM_SETTLE_NS 2000
`define SDM_SETTLE_CLKS ((`SDM_SETTLE_NS + `SDM_CLK_NS - 1) / `SDM_CLK_NS)

// ****************************************************************
// register offsets
// ****************************************************************
`define SDM_CTRL_OFS 8'h00
`define SDM_STATUS_OFS 8'h04
`define SDM_FILT_EN_OFS 8'h08
`define SDM_TEST_EN_OFS 8'h0C
`define SDM_ROLE_OFS 8'h10
`define SDM_FILT_MS_OFS 8'h20
`define SDM_OUT_MAP_OFS 8'h30

// ****************************************************************
// fields and reset values
// ****************************************************************
`define SDM_CTRL_RUN 0
`define SDM_CTRL_CLR 1
`define SDM_ST_STATE 12
`define SDM_ST_WIRE 16
`define SDM_ST_OV 17
`define SDM_ROLE_TOA_EN 2
`define SDM_ROLE_BT 4
`define SDM_ROLE_BT_EN 6
`define SDM_FILT_MS_RST 8'h01
`define SDM_TEST_EN_RST 8'hFF

`endif

/* File: verilog/sdm_pkg.sv */
// types shared by the safe digital io mapper
package sdm_pkg;

  typedef enum logic [1:0] {
    SDM_RUN  = 2'b00,
    SDM_STOP = 2'b01,
    SDM_TOFF = 2'b10
  } sdm_state_t;

endpackage

/* File: verilog/sdm_in_filter.sv */
// per-input pulse suppression filter stepping once per module cycle
`timescale 1ns/1ns
module sdm_in_filter #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic sample,
  input wire logic en,
  input wire logic [CW-1:0] limit,
  output logic image
);

  logic [CW-1:0] cnt_q;

  // integrating up/down counter: the image only flips once the level has
  // outweighed the opposite level for a whole filter time, so a short
  // glitch of either polarity is absorbed, like a first-order low pass
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      image <= 1'b0;
    end else if (tick) begin
      if (!en || limit == '0) begin
        cnt_q <= sample ? limit : '0;
        image <= sample;
      end else if (sample) begin
        if (cnt_q >= limit - 1'b1) begin
          cnt_q <= limit;
          image <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else begin
        if (cnt_q <= 1) begin
          cnt_q <= '0;
          image <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule

/* File: verilog/sdm_top.sv */
// safe digital input/output mapper with test pulses and fault stop
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "sdm_map.svh"

module sdm_top import sdm_pkg::*; #(
  parameter int N = 4,
  parameter int CYCLE_CLKS = `SDM_CYCLE_CLKS,
  parameter int TP_CLKS = `SDM_TP_CLKS,
  parameter int TP_REP = `SDM_TP_REP_CYC,
  parameter int SETTLE_CLKS = `SDM_SETTLE_CLKS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N-1:0] IN_PINS,
  output logic [N-1:0] IN_TEST,
  input wire logic [N-1:0] SF_SAFE,
  output logic [N-1:0] SF_ACTIVE,
  input wire logic STANDSTILL,
  input wire logic BRAKE_TEST,
  input wire logic [N-1:0] OUT_FB,
  output logic [N-1:0] OUT_PINS,
  output logic SAFE_STOP_REQ,
  output logic TORQUE_OFF_ACK
);

  localparam int IW = $clog2(N);

  // ****************************************************************
  // register file
  // ****************************************************************
  logic run_q;
  logic [N-1:0] filt_en_q;
  logic [N-1:0] on_en_q;
  logic [N-1:0] off_en_q;
  logic [IW-1:0] toa_idx_q;
  logic toa_en_q;
  logic [IW-1:0] bt_idx_q;
  logic bt_en_q;
  logic [7:0] filt_ms_q [N];
  logic [N-1:0] map_q [N];
  logic wire_flt_q;
  logic ov_flt_q;
  logic clr_q;
  sdm_state_t state_q;
  logic [N-1:0] image;
  logic [N-1:0] fb_q;
  logic access;
  logic wr;
  logic [31:0] rdata;
  logic hit;

  assign access = PSEL && PENABLE && !PREADY;
  assign wr = access && PWRITE;

  function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs, input int i);
    sel = (a == ofs + 8'(4 * i));
  endfunction

  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    unique case (PADDR)
      `SDM_CTRL_OFS: rdata[`SDM_CTRL_RUN] = run_q;
      `SDM_STATUS_OFS: begin
        rdata[N-1:0] = image;
        rdata[4 +: N] = SF_ACTIVE;
        rdata[8 +: N] = fb_q;
        rdata[`SDM_ST_STATE +: 2] = state_q;
        rdata[`SDM_ST_WIRE] = wire_flt_q;
        rdata[`SDM_ST_OV] = ov_flt_q;
      end
      `SDM_FILT_EN_OFS: rdata[N-1:0] = filt_en_q;
      `SDM_TEST_EN_OFS: begin
        rdata[N-1:0] = on_en_q;
        rdata[4 +: N] = off_en_q;
      end
      `SDM_ROLE_OFS: begin
        rdata[IW-1:0] = toa_idx_q;
        rdata[`SDM_ROLE_TOA_EN] = toa_en_q;
        rdata[`SDM_ROLE_BT +: IW] = bt_idx_q;
        rdata[`SDM_ROLE_BT_EN] = bt_en_q;
      end
      default: begin
        hit = 1'b0;
        for (int i = 0; i < N; i++) begin
          if (sel(PADDR, `SDM_FILT_MS_OFS, i)) begin
            rdata[7:0] = filt_ms_q[i];
            hit = 1'b1;
          end
          if (sel(PADDR, `SDM_OUT_MAP_OFS, i)) begin
            rdata[N-1:0] = map_q[i];
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // one wait state: the answer is registered on the first access edge
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= access;
      PSLVERR <= access && !hit;
      if (access && !PWRITE) begin
        PRDATA <= rdata;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      run_q <= 1'b0;
      clr_q <= 1'b0;
      filt_en_q <= '1;
      on_en_q <= N'(`SDM_TEST_EN_RST);
      off_en_q <= N'(`SDM_TEST_EN_RST);
      toa_idx_q <= '0;
      toa_en_q <= 1'b0;
      bt_idx_q <= '0;
      bt_en_q <= 1'b0;
      for (int i = 0; i < N; i++) begin
        filt_ms_q[i] <= `SDM_FILT_MS_RST;
        map_q[i] <= '0;
      end
    end else begin
      clr_q <= wr && PADDR == `SDM_CTRL_OFS && PWDATA[`SDM_CTRL_CLR];
      if (wr) begin
        unique case (PADDR)
          `SDM_CTRL_OFS: run_q <= PWDATA[`SDM_CTRL_RUN];
          `SDM_FILT_EN_OFS: filt_en_q <= PWDATA[N-1:0];
          `SDM_TEST_EN_OFS: begin
            on_en_q <= PWDATA[N-1:0];
            off_en_q <= PWDATA[4 +: N];
          end
          `SDM_ROLE_OFS: begin
            toa_idx_q <= PWDATA[IW-1:0];
            toa_en_q <= PWDATA[`SDM_ROLE_TOA_EN];
            bt_idx_q <= PWDATA[`SDM_ROLE_BT +: IW];
            bt_en_q <= PWDATA[`SDM_ROLE_BT_EN];
          end
          default: begin
            for (int i = 0; i < N; i++) begin
              if (sel(PADDR, `SDM_FILT_MS_OFS, i)) begin
                filt_ms_q[i] <= PWDATA[7:0];
              end
              if (sel(PADDR, `SDM_OUT_MAP_OFS, i)) begin
                map_q[i] <= PWDATA[N-1:0];
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // module cycle and test pulse timing
  // ****************************************************************
  logic [31:0] cyc_cnt_q;
  logic tick_q;
  logic [7:0] rep_q;
  logic [15:0] tp_cnt_q;
  logic tp_on;

  assign tp_on = tp_cnt_q != 16'h0000;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cyc_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (!run_q) begin
      cyc_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= cyc_cnt_q == 32'(CYCLE_CLKS - 1);
      cyc_cnt_q <= (cyc_cnt_q == 32'(CYCLE_CLKS - 1)) ? 32'h0000_0000 : cyc_cnt_q + 1'b1;
    end
  end

  // one test pulse of fixed width every TP_REP module cycles
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rep_q <= 8'h00;
      tp_cnt_q <= 16'h0000;
    end else begin
      if (tp_on) begin
        tp_cnt_q <= tp_cnt_q - 1'b1;
      end
      if (tick_q) begin
        if (rep_q == 8'(TP_REP - 1)) begin
          rep_q <= 8'h00;
          tp_cnt_q <= 16'(TP_CLKS);
        end else begin
          rep_q <= rep_q + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // inputs
  // ****************************************************************
  logic [N-1:0] in_s1_q;
  logic [N-1:0] in_s2_q;
  logic [N-1:0] smp_q;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      in_s1_q <= '0;
      in_s2_q <= '0;
      smp_q <= '0;
      IN_TEST <= '0;
    end else begin
      in_s1_q <= IN_PINS;
      in_s2_q <= in_s1_q;
      if (tick_q) begin
        smp_q <= in_s2_q;
      end
      IN_TEST <= tick_q ? smp_q : '0;
    end
  end

  generate
    for (genvar g = 0; g < N; g++) begin : g_filt
      sdm_in_filter #(.CW(16)) u_filt (
        .clk(CLK),
        .rst_n(RESET_N),
        .tick(tick_q),
        .sample(smp_q[g]),
        .en(filt_en_q[g]),
        .limit(16'(filt_ms_q[g] * `SDM_CYC_PER_MS)),
        .image(image[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SF_ACTIVE <= '0;
    end else begin
      SF_ACTIVE <= ~image;
    end
  end

  // ****************************************************************
  // feedback outputs
  // ****************************************************************
  // combine the feedback of every active function mapped to one output
  function automatic logic combine(input logic [N-1:0] m, input logic [N-1:0] act,
                                   input logic [N-1:0] safe);
    logic [N-1:0] c;
    c = m & act;
    combine = (c != '0) && ((c & ~safe) == '0);
  endfunction

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fb_q <= '0;
    end else if (tick_q) begin
      for (int o = 0; o < N; o++) begin
        if (state_q == SDM_TOFF) begin
          fb_q[o] <= 1'b0;
          if (toa_en_q && IW'(o) == toa_idx_q) begin
            fb_q[o] <= 1'b1;
          end
          if (bt_en_q && IW'(o) == bt_idx_q && BRAKE_TEST) begin
            fb_q[o] <= fb_q[o];
          end
        end else if (bt_en_q && IW'(o) == bt_idx_q && BRAKE_TEST) begin
          fb_q[o] <= fb_q[o];
        end else begin
          fb_q[o] <= combine(map_q[o], SF_ACTIVE, SF_SAFE);
        end
      end
    end
  end

  // test pulses invert each output briefly; the load must ride through them
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      OUT_PINS <= '0;
    end else begin
      for (int o = 0; o < N; o++) begin
        if (tp_on && fb_q[o] && off_en_q[o]) begin
          OUT_PINS[o] <= 1'b0;
        end else if (tp_on && !fb_q[o] && on_en_q[o]) begin
          OUT_PINS[o] <= 1'b1;
        end else begin
          OUT_PINS[o] <= fb_q[o];
        end
      end
    end
  end

  // ****************************************************************
  // wiring and overvoltage supervision
  // ****************************************************************
  logic [N-1:0] fb_s1_q;
  logic [N-1:0] fb_s2_q;
  logic [N-1:0] out_d1_q;
  logic [15:0] stable_q;
  logic stable;
  logic wire_evt;
  logic ov_evt;
  logic [N-1:0] toa_mask;

  // readback lags the pins, so compare only once they have settled;
  // a pin change in this very cycle must block the compare at once
  assign stable = stable_q == 16'(SETTLE_CLKS) && out_d1_q == OUT_PINS;
  assign toa_mask = N'(1) << toa_idx_q;
  assign wire_evt = stable && fb_s2_q != OUT_PINS;
  assign ov_evt = stable && toa_en_q && |(fb_s2_q & toa_mask)
                  && |(fb_s2_q & ~toa_mask);

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fb_s1_q <= '0;
      fb_s2_q <= '0;
      out_d1_q <= '0;
      stable_q <= 16'h0000;
    end else begin
      fb_s1_q <= OUT_FB;
      fb_s2_q <= fb_s1_q;
      out_d1_q <= OUT_PINS;
      if (out_d1_q != OUT_PINS) begin
        stable_q <= 16'h0000;
      end else if (!stable) begin
        stable_q <= stable_q + 1'b1;
      end
    end
  end

  // a new fault wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wire_flt_q <= 1'b0;
      ov_flt_q <= 1'b0;
    end else begin
      wire_flt_q <= wire_evt || (wire_flt_q && !clr_q);
      ov_flt_q <= ov_evt || (ov_flt_q && !clr_q);
    end
  end

  // ****************************************************************
  // stop sequence
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q <= SDM_RUN;
    end else begin
      unique case (state_q)
        SDM_RUN: if (wire_evt || ov_evt) begin
          state_q <= SDM_STOP;
        end
        SDM_STOP: if (STANDSTILL) begin
          state_q <= SDM_TOFF;
        end
        // the flags fall on the same edge as the clear, so gate on live events
        SDM_TOFF: if (clr_q && !wire_evt && !ov_evt) begin
          state_q <= SDM_RUN;
        end
        default: state_q <= SDM_STOP;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SAFE_STOP_REQ <= 1'b0;
      TORQUE_OFF_ACK <= 1'b0;
    end else begin
      SAFE_STOP_REQ <= state_q != SDM_RUN;
      TORQUE_OFF_ACK <= state_q == SDM_TOFF;
    end
  end

endmodule

/* File: dv/sdm_top_asserts.sv */
// port-level checker for the safe digital io mapper
`timescale 1ns/1ns
module sdm_top_asserts #(
  parameter int N = 4,
  parameter int CYCLE_CLKS = 20,
  parameter int TP_CLKS = 3
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [N-1:0] IN_TEST,
  input wire logic [N-1:0] SF_ACTIVE,
  input wire logic STANDSTILL,
  input wire logic [N-1:0] OUT_PINS,
  input wire logic SAFE_STOP_REQ,
  input wire logic TORQUE_OFF_ACK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  int inact_q;
  int hi_q;
  // ********
  // helper counters
  // ********
  // saturate so long idle stretches cannot wrap
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      inact_q <= 0;
    end else if (SF_ACTIVE == '0 && !TORQUE_OFF_ACK) begin
      inact_q <= (inact_q < 1000) ? inact_q + 1 : inact_q;
    end else begin
      inact_q <= 0;
    end
  end
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hi_q <= 0;
    end else begin
      hi_q <= OUT_PINS[0] ? ((hi_q < 1000) ? hi_q + 1 : hi_q) : 0;
    end
  end
  // ********
  // properties
  // ********
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  a_ready_follows: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no pready after access edge");
  a_err_with_rdy: assert property (PSLVERR |-> PREADY)
    else $error("pslverr without pready");
  a_test_pulse: assert property (IN_TEST != '0 |=> IN_TEST == '0)
    else $error("input test pulse wider than one clock");
  a_toff_after_stop: assert property ($rose(TORQUE_OFF_ACK) |->
    $past(SAFE_STOP_REQ) && $past(STANDSTILL))
    else $error("torque off without safe stop and standstill");
  a_toff_in_stop: assert property (TORQUE_OFF_ACK |-> SAFE_STOP_REQ)
    else $error("torque off ack while stop not requested");
  a_stop_release: assert property ($fell(SAFE_STOP_REQ) |-> $past(TORQUE_OFF_ACK))
    else $error("safe stop left without torque off");
  a_out_idle: assert property (inact_q > CYCLE_CLKS + TP_CLKS + 4 |-> hi_q <= TP_CLKS)
    else $error("output high with no active function");
endmodule

bind sdm_top sdm_top_asserts #(.N(N), .CYCLE_CLKS(CYCLE_CLKS), .TP_CLKS(TP_CLKS)) u_sdm_chk (
  .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .IN_TEST(IN_TEST), .SF_ACTIVE(SF_ACTIVE), .STANDSTILL(STANDSTILL),
  .OUT_PINS(OUT_PINS), .SAFE_STOP_REQ(SAFE_STOP_REQ), .TORQUE_OFF_ACK(TORQUE_OFF_ACK));

/* File: dv/sdm_ctrl_model.sv */
// safety controller model reading back the safe outputs
`timescale 1ns/1ns
module sdm_ctrl_model #(
  parameter int TOA = 3
) (
  input wire logic [3:0] out_pins,
  input wire logic [3:0] force_hi,
  output logic [3:0] out_fb,
  output logic plaus_err
);
  // a forced bit stands for a short to supply on that wire
  assign out_fb = out_pins | force_hi;
  // ack high together with any other feedback high is implausible
  assign plaus_err = out_fb[TOA] & |(out_fb & ~(4'h1 << TOA));
endmodule

/* File: dv/sdm_top_bench.sv */
// self-checking bench for the safe digital io mapper
`timescale 1ns/1ns
`include "sdm_map.svh"
module sdm_top_bench;
  localparam int CYC = 20;
  localparam int TP = 3;
  localparam int REP = 8;
  localparam int LIM = 4;
  logic CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic STANDSTILL, BRAKE_TEST, SAFE_STOP_REQ, TORQUE_OFF_ACK, plaus_err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic err;
  logic [3:0] IN_PINS, IN_TEST, SF_SAFE, SF_ACTIVE, OUT_FB, OUT_PINS, force_hi;
  int num_errors = 0;
  int checked = 0;
  sdm_top #(.N(4), .CYCLE_CLKS(CYC), .TP_CLKS(TP), .TP_REP(REP), .SETTLE_CLKS(4)) u_sdm_top (
    .CLK(CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .IN_PINS(IN_PINS), .IN_TEST(IN_TEST), .SF_SAFE(SF_SAFE), .SF_ACTIVE(SF_ACTIVE),
    .STANDSTILL(STANDSTILL), .BRAKE_TEST(BRAKE_TEST), .OUT_FB(OUT_FB), .OUT_PINS(OUT_PINS),
    .SAFE_STOP_REQ(SAFE_STOP_REQ), .TORQUE_OFF_ACK(TORQUE_OFF_ACK));
  sdm_ctrl_model #(.TOA(3)) u_sdm_ctrl_model (.out_pins(OUT_PINS), .force_hi(force_hi),
    .out_fb(OUT_FB), .plaus_err(plaus_err));
  // ********
  // tasks
  // ********
  task automatic end_sim;
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(rd, e);
  endtask
  // two spare clocks let levels registered after the last tick settle
  task automatic ticks(input int n);
    repeat (n * CYC + 2) @(posedge CLK);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs;
    rdc(`SDM_FILT_EN_OFS, 32'hF);
    rdc(`SDM_FILT_MS_OFS + 8'h0C, 32'h1);
    rdc(`SDM_TEST_EN_OFS, 32'hFF);
    rdc(`SDM_ROLE_OFS, 32'h0);
    cmp(32'(err), 32'h0);
    rdc(8'h40, 32'h0);
    cmp(32'(err), 32'h1);
  endtask
  task automatic t_inputs;
    int n;
    apb(1'b1, `SDM_FILT_EN_OFS, 32'h7);
    apb(1'b1, `SDM_CTRL_OFS, 32'h1);
    IN_PINS <= 4'hF;
    ticks(LIM + 3);
    cmp(32'(SF_ACTIVE), 32'h0);
    for (n = 0; n < CYC + 2 && IN_TEST == 4'h0; n++) @(posedge CLK);
    cmp(32'(IN_TEST), 32'hF);
    IN_PINS <= 4'h3;
    ticks(2);
    cmp(32'(SF_ACTIVE), 32'h8);
    IN_PINS <= 4'hF;
    ticks(LIM + 1);
    IN_PINS <= 4'hB;
    ticks(LIM + 2);
    cmp(32'(SF_ACTIVE), 32'h4);
    IN_PINS <= 4'hC;
    ticks(LIM + 3);
    cmp(32'(SF_ACTIVE), 32'h3);
  endtask
  task automatic t_outputs;
    apb(1'b1, `SDM_TEST_EN_OFS, 32'h0);
    apb(1'b1, `SDM_OUT_MAP_OFS, 32'h3);
    apb(1'b1, `SDM_OUT_MAP_OFS + 8'h04, 32'h2);
    apb(1'b1, `SDM_OUT_MAP_OFS + 8'h08, 32'h4);
    SF_SAFE <= 4'hF;
    ticks(2);
    cmp(32'(OUT_PINS), 32'h3);
    SF_SAFE <= 4'hD;
    ticks(2);
    cmp(32'(OUT_PINS), 32'h0);
    IN_PINS <= 4'hE;
    ticks(LIM + 3);
    cmp(32'(OUT_PINS), 32'h1);
  endtask
  task automatic t_pulses;
    int n;
    int w;
    apb(1'b1, `SDM_TEST_EN_OFS, 32'hFF);
    for (n = 0; n < 400 && OUT_PINS[0] !== 1'b0; n++) @(posedge CLK);
    cmp(32'(OUT_PINS[2]), 32'h1);
    for (w = 0; w < 50 && OUT_PINS[0] === 1'b0; w++) @(posedge CLK);
    cmp(32'(w), 32'(TP));
    for (n = 0; n < 400 && OUT_PINS[0] !== 1'b0; n++) @(posedge CLK);
    cmp(32'(n + TP), 32'(REP * CYC));
  endtask
  task automatic t_fault;
    int n;
    apb(1'b1, `SDM_TEST_EN_OFS, 32'h0);
    apb(1'b1, `SDM_ROLE_OFS, 32'h47);
    BRAKE_TEST <= 1'b1;
    force_hi <= 4'h4;
    for (n = 0; n < 99 && SAFE_STOP_REQ !== 1'b1; n++) @(posedge CLK);
    cmp(32'(SAFE_STOP_REQ), 32'h1);
    cmp(32'(TORQUE_OFF_ACK), 32'h0);
    STANDSTILL <= 1'b1;
    for (n = 0; n < 20 && TORQUE_OFF_ACK !== 1'b1; n++) @(posedge CLK);
    cmp(32'(TORQUE_OFF_ACK), 32'h1);
    ticks(2);
    cmp(32'(OUT_PINS), 32'h9);
    apb(1'b0, `SDM_STATUS_OFS, 32'h0);
    cmp(rd & 32'h0001_3000, 32'h0001_2000);
    force_hi <= 4'h0;
    BRAKE_TEST <= 1'b0;
    STANDSTILL <= 1'b0;
    ticks(2);
    cmp(32'(OUT_PINS), 32'h8);
    apb(1'b1, `SDM_CTRL_OFS, 32'h3);
    apb(1'b0, `SDM_STATUS_OFS, 32'h0);
    cmp(rd & 32'h0003_3000, 32'h0);
    cmp(32'(SAFE_STOP_REQ), 32'h0);
  endtask
  task automatic t_ovr;
    int n;
    ticks(2);
    force_hi <= 4'h8;
    for (n = 0; n < 99 && SAFE_STOP_REQ !== 1'b1; n++) @(posedge CLK);
    cmp(32'(SAFE_STOP_REQ), 32'h1);
    cmp(32'(plaus_err), 32'h1);
    apb(1'b0, `SDM_STATUS_OFS, 32'h0);
    cmp(32'(rd[17]), 32'h1);
  endtask
  // ********
  // run
  // ********
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // the full run takes about 1300 clocks; the limit allows about 25000
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
  initial begin
    RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    IN_PINS = 4'h0;
    SF_SAFE = 4'h0;
    STANDSTILL = 1'b0;
    BRAKE_TEST = 1'b0;
    force_hi = 4'h0;
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    @(posedge CLK);
    t_regs;
    t_inputs;
    t_outputs;
    t_pulses;
    t_fault;
    t_ovr;
    end_sim;
  end
endmodule
